// ### logic/qtx_ctrl.sv
// top: quad transmit enable latches, self-test latch and channel control
// Summary of operation
// - control bits pick data, fill, special or word sync; select ignored.
// - word sync starts only when both control bits sampled high.
// - sixteen-character sync is atomic; a start is ignored until its last character has gone out.
// - second and third sync characters carry inverted disparity.
// - starting character needs odd parity when checked; rest unchecked.
// - latch enable high: low enable bit starts that channel's generator.
// - generator is an lfsr repeating a 511 character sequence.
// - self-test latch enable low holds captured enable bits.
// - reset presets self-test latch, generators off on all channels.
// - self-test channel ignores its data byte and control bits.
// - enable bits 1,3,5,7 drive self-test of channels A to D.
// - output latch enable high passes bits; low bit powers driver down.
// - both drivers of a channel off powers down that channel.
// - output latch enable low holds the enable bits.
// - enable bits 0 to 7 control drivers A1 through D2 in order.
// - reset clears output enables: all drivers and channels off.
// - bit clock is reference times 10 or 20, plus character clock.
// - speed select fixes rate range; half-rate lowest range reserved.
// - latch enable high with bits high enables channels after reset.
`timescale 1ns/1ps
module qtx_ctrl
	import qtx_pkg::*;
#(
	parameter int NCH = QTX_NCH
)(
	// clock and reset (i_rst is the sampled device reset)
	input wire logic i_clk,
	input wire logic i_rst,
	// enable latches
	input wire logic [2*NCH-1:0] i_enable_bus,
	input wire logic i_output_latch_enable,
	input wire logic i_selftest_latch_enable,
	// static configuration
	input wire logic i_special_code_select,
	input wire logic i_reference_clock_in_rate_select,
	input wire qtx_cksel_e i_input_clock_select,
	input wire qtx_spd_e i_speed_range_select,
	input wire logic i_parity_check,
	// per channel characters
	input wire qtx_char_s [NCH-1:0] i_char,
	// outputs
	output qtx_out_s [NCH-1:0] o_out,
	output logic [NCH-1:0] o_sync_busy,
	output logic [2*NCH-1:0] o_driver_enable,
	output logic [NCH-1:0] o_chan_power,
	output logic [NCH-1:0] o_bist_active,
	output logic [4:0] o_clock_multiplier,
	output logic o_config_invalid
);
	logic [2*NCH-1:0] oe_latch_reg;
	logic [NCH-1:0] bist_latch_reg;
	logic [NCH-1:0] bist_bits;
	logic [NCH-1:0] chan_on;
	logic [4:0] mul_reg;
	logic inval_reg;

	function automatic logic [NCH-1:0] odd_bits(input logic [2*NCH-1:0] b);
		logic [NCH-1:0] r;
		r = '0;
		for (int i = 0; i < NCH; i++) begin
			r[i] = b[2*i+1];
		end
		return r;
	endfunction : odd_bits

	assign bist_bits = odd_bits(i_enable_bus);

	////////////////////////////////////////////////////////////////////////
	// output enable latch, bit i drives driver i (A1,A2,B1..D2)
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			oe_latch_reg <= QTX_OE_OFF;
		end else if (i_output_latch_enable) begin
			oe_latch_reg <= i_enable_bus;
		end
	end // held when enable low

	// self-test latch stores the inverted bit so one means generator on
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bist_latch_reg <= ~QTX_BIST_OFF;
		end else if (i_selftest_latch_enable) begin
			bist_latch_reg <= ~bist_bits;
		end
	end // held when enable low

	// configuration decode; combinations the host must avoid are flagged
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mul_reg <= 5'(QTX_MUL_FULL);
			inval_reg <= 1'b0;
		end else begin
			mul_reg <= i_reference_clock_in_rate_select ? 5'(QTX_MUL_HALF)
				: 5'(QTX_MUL_FULL);
			inval_reg <= (i_reference_clock_in_rate_select &&
				i_input_clock_select != QTX_CK_REF) ||
				(i_reference_clock_in_rate_select &&
				i_speed_range_select == QTX_SPD_LOW);
		end
	end

	////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			assign chan_on[g] = oe_latch_reg[2*g] | oe_latch_reg[2*g+1];
			qtx_chan u_chan (
				.i_clk(i_clk),
				.i_rst(i_rst),
				.i_bist_en(bist_latch_reg[g]),
				.i_chan_on(chan_on[g]),
				.i_parity_check(i_parity_check),
				.i_char(i_char[g]),
				.o_out(o_out[g]),
				.o_sync_busy(o_sync_busy[g])
			);
		end
	endgenerate

	assign o_driver_enable = oe_latch_reg;
	assign o_chan_power = chan_on;
	assign o_bist_active = bist_latch_reg;
	assign o_clock_multiplier = mul_reg;
	assign o_config_invalid = inval_reg;

	////////////////////////////////////////////////////////////////////////
	property p_oe_pass;
		@(posedge i_clk) disable iff (i_rst)
		i_output_latch_enable |=> oe_latch_reg == $past(i_enable_bus);
	endproperty
	a_oe_pass: assert property (p_oe_pass)
		else $error("oe not transparent");

	property p_oe_hold;
		@(posedge i_clk) disable iff (i_rst)
		!i_output_latch_enable |=> $stable(oe_latch_reg);
	endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("oe latch moved");

	property p_oe_reset;
		@(posedge i_clk) i_rst |=> o_driver_enable == QTX_OE_OFF && !(|o_chan_power);
	endproperty
	a_oe_reset: assert property (p_oe_reset)
		else $error("reset left oe on");

	property p_bist_reset;
		@(posedge i_clk) i_rst |=> o_bist_active == '0;
	endproperty
	a_bist_reset: assert property (p_bist_reset)
		else $error("bist on after reset");

	property p_bist_hold;
		@(posedge i_clk) disable iff (i_rst)
		!i_selftest_latch_enable |=> $stable(bist_latch_reg);
	endproperty
	a_bist_hold: assert property (p_bist_hold)
		else $error("bist latch moved");

	property p_bist_map;
		@(posedge i_clk) disable iff (i_rst)
		i_selftest_latch_enable && !i_enable_bus[1] |=> o_bist_active[0];
	endproperty
	a_bist_map: assert property (p_bist_map)
		else $error("bist map wrong");

	// an unpowered channel must go quiet, not only report it
	property p_power;
		@(posedge i_clk) disable iff (i_rst)
		o_driver_enable[1:0] == 2'h0 |=> o_out[0].kind == QTX_OUT_OFF;
	endproperty
	a_power: assert property (p_power)
		else $error("channel powered");

	property p_mul;
		@(posedge i_clk) disable iff (i_rst)
		i_reference_clock_in_rate_select |=> o_clock_multiplier == 5'(QTX_MUL_HALF);
	endproperty
	a_mul: assert property (p_mul)
		else $error("multiplier wrong");

	property p_reserved;
		@(posedge i_clk) disable iff (i_rst)
		i_reference_clock_in_rate_select && i_speed_range_select == QTX_SPD_LOW
			|=> o_config_invalid;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved speed not flagged");

	// every odd bit steers its own channel; even bits must not leak in
	generate
		for (g = 0; g < NCH; g++) begin : g_chk
			property p_bist_lane;
				@(posedge i_clk) disable iff (i_rst)
				i_selftest_latch_enable |=>
					o_bist_active[g] == !$past(i_enable_bus[2*g+1]);
			endproperty
			a_bist_lane: assert property (p_bist_lane)
				else $error("bist lane map wrong");
		end
	endgenerate

	c_strap: cover property (@(posedge i_clk) $fell(i_rst) ##1 (&o_driver_enable));
	c_latch: cover property (@(posedge i_clk) $fell(i_output_latch_enable));
	c_bist_on: cover property (@(posedge i_clk) |o_bist_active);
endmodule : qtx_ctrl

// ### logic/qtx_pkg.sv
// package: constants, types and structs for the quad transmit control block
package qtx_pkg;
	localparam int QTX_NCH = 4;
	localparam int QTX_NBOE = 8;
	localparam int QTX_SYNC_LEN = 16;
	localparam logic [3:0] QTX_SYNC_LAST = 4'h f;
	localparam logic [8:0] QTX_LFSR_SEED = 9'h 1ff;
	localparam logic [1:0] QTX_CTL_DATA = 2'h 0;
	localparam logic [1:0] QTX_CTL_FILL = 2'h 1;
	localparam logic [1:0] QTX_CTL_SPEC = 2'h 2;
	localparam logic [1:0] QTX_CTL_SYNC = 2'h 3;
	// word sync disparity flip of characters 2 and 3
	localparam logic [15:0] QTX_SYNC_FLIP = 16'h 0006;
	localparam logic [3:0] QTX_BIST_OFF = 4'h f;
	localparam logic [7:0] QTX_OE_OFF = 8'h 00;
	localparam int QTX_MUL_FULL = 10;
	localparam int QTX_MUL_HALF = 20;
	localparam real QTX_SETTLE_US = 200.0;
	localparam real QTX_CLK_MHZ = 250.0;
	localparam int QTX_SETTLE_CYC = int'(QTX_SETTLE_US * QTX_CLK_MHZ);
	typedef enum logic [1:0] {QTX_SPD_LOW, QTX_SPD_MID, QTX_SPD_HIGH} qtx_spd_e;
	typedef enum logic [1:0] {QTX_CK_REF, QTX_CK_CHAN, QTX_CK_CHA} qtx_cksel_e;
	typedef enum logic [2:0] {
		QTX_OUT_DATA, QTX_OUT_FILL, QTX_OUT_SPEC, QTX_OUT_SYNC, QTX_OUT_BIST,
		QTX_OUT_OFF
	} qtx_kind_e;
	typedef struct packed {
		logic [7:0] tx_data_byte;
		logic [1:0] char_control_bits;
		logic parity_ok;
	} qtx_char_s;
	typedef struct packed {
		qtx_kind_e kind;
		logic [8:0] data;
		logic invert_disp;
	} qtx_out_s;
endpackage : qtx_pkg

// ### logic/qtx_chan.sv
// one transmit channel: character select, atomic word sync, bist lfsr
`timescale 1ns/1ps
module qtx_chan
	import qtx_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control
	input wire logic i_bist_en,
	input wire logic i_chan_on,
	input wire logic i_parity_check,
	input wire qtx_char_s i_char,
	// output
	output qtx_out_s o_out,
	output logic o_sync_busy
);
	logic [3:0] sync_cnt_reg;
	logic sync_act_reg;
	logic [8:0] lfsr_reg;
	logic sync_start;
	qtx_out_s out_reg;

	// start needs both control bits high and odd parity when checked
	assign sync_start = (i_char.char_control_bits == QTX_CTL_SYNC) &&
		(!i_parity_check || i_char.parity_ok) && !i_bist_en;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_chan_on || i_bist_en) begin
			sync_act_reg <= 1'b0;
			sync_cnt_reg <= '0;
		end else if (sync_act_reg && sync_cnt_reg != QTX_SYNC_LAST) begin
			sync_cnt_reg <= sync_cnt_reg + 4'h 1;
		end else if (sync_start) begin
			sync_act_reg <= 1'b1;
			sync_cnt_reg <= '0;
		end else begin
			sync_act_reg <= 1'b0;
			sync_cnt_reg <= '0;
		end
	end

	// x^9 + x^5 + 1 gives the 511 state cycle
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_bist_en) begin
			lfsr_reg <= QTX_LFSR_SEED;
		end else begin
			lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_chan_on) begin
			out_reg <= '{kind: QTX_OUT_OFF, data: '0, invert_disp: 1'b0};
		end else if (i_bist_en) begin
			// inputs ignored in self test
			out_reg <= '{kind: QTX_OUT_BIST, data: lfsr_reg, invert_disp: 1'b0};
		end else if (sync_act_reg && sync_cnt_reg != QTX_SYNC_LAST) begin
			out_reg <= '{kind: QTX_OUT_SYNC, data: '0,
				invert_disp: QTX_SYNC_FLIP[sync_cnt_reg + 4'h 1]};
		end else if (sync_start) begin
			out_reg <= '{kind: QTX_OUT_SYNC, data: '0, invert_disp: 1'b0};
		end else begin
			case (i_char.char_control_bits)
				QTX_CTL_DATA: out_reg <= '{kind: QTX_OUT_DATA,
					data: {1'b0, i_char.tx_data_byte}, invert_disp: 1'b0};
				QTX_CTL_FILL: out_reg <= '{kind: QTX_OUT_FILL, data: '0,
					invert_disp: 1'b0};
				QTX_CTL_SPEC: out_reg <= '{kind: QTX_OUT_SPEC,
					data: {1'b0, i_char.tx_data_byte}, invert_disp: 1'b0};
				default: out_reg <= '{kind: QTX_OUT_FILL, data: '0,
					invert_disp: 1'b0};
			endcase
		end
	end
	assign o_out = out_reg;
	assign o_sync_busy = sync_act_reg;

	////////////////////////////////////////////////////////////////////////
	property p_sync_len;
		@(posedge i_clk) disable iff (i_rst)
		$rose(sync_act_reg) && i_chan_on && !i_bist_en |->
			sync_act_reg [*8];
	endproperty
	a_sync_len: assert property (p_sync_len)
		else $error("sync cut short");

	property p_flip;
		@(posedge i_clk) disable iff (i_rst)
		sync_act_reg && sync_cnt_reg == 4'h 0 && i_chan_on && !i_bist_en
			|=> out_reg.invert_disp;
	endproperty
	a_flip: assert property (p_flip)
		else $error("second sync char not flipped");

	property p_bist_kind;
		@(posedge i_clk) disable iff (i_rst)
		i_bist_en && i_chan_on |=> out_reg.kind == QTX_OUT_BIST;
	endproperty
	a_bist_kind: assert property (p_bist_kind)
		else $error("bist not output");

	property p_lfsr_nz;
		@(posedge i_clk) disable iff (i_rst) lfsr_reg != 9'h 000;
	endproperty
	a_lfsr_nz: assert property (p_lfsr_nz)
		else $error("lfsr locked up");

	c_sync: cover property (@(posedge i_clk) $rose(sync_act_reg));
	c_bist: cover property (@(posedge i_clk) out_reg.kind == QTX_OUT_BIST);
endmodule : qtx_chan

// ### testbench/qtx_rx_model.sv
// remote receiver model: measures the self-test pattern period on one lane
`timescale 1ns/1ps
module qtx_rx_model
	import qtx_pkg::*;
(
	// clock
	input wire logic i_clk,
	// lane under watch
	input wire qtx_out_s i_out,
	// measured result
	output logic [9:0] o_period = 10'h000,
	output logic o_done = 1'b0
);
	logic [8:0] first_reg = 9'h000;
	logic armed_reg = 1'b0;

	// locks onto the first pattern word, counts until it comes back;
	// a short loop shows up as a period below the full length
	always @(posedge i_clk) begin
		if (i_out.kind !== QTX_OUT_BIST) begin
			armed_reg <= 1'b0;
		end else if (!armed_reg) begin
			armed_reg <= 1'b1;
			first_reg <= i_out.data;
			o_period <= 10'h001;
			o_done <= 1'b0;
		end else if (!o_done) begin
			if (i_out.data === first_reg)
				o_done <= 1'b1;
			else
				o_period <= o_period + 10'h001;
		end
	end
endmodule : qtx_rx_model

// ### testbench/testbench.sv
// self-checking bench for the quad transmit control block
`timescale 1ns/1ps
module testbench;
	import qtx_pkg::*;
	logic clk, rst, ole, stle, scs, rate, pc;
	logic [7:0] bus;
	qtx_cksel_e cksel;
	qtx_spd_e spd;
	qtx_char_s [3:0] ch;
	qtx_out_s [3:0] out;
	logic [3:0] busy, pwr, bist;
	logic [7:0] drv;
	logic [4:0] mult;
	logic inval, rx_done;
	logic [9:0] rx_period;
	int n_errors = 0;
	int total_checks = 0;

	qtx_ctrl #(.NCH(4)) i_qtx_ctrl (.i_clk(clk), .i_rst(rst),
		.i_enable_bus(bus), .i_output_latch_enable(ole),
		.i_selftest_latch_enable(stle), .i_special_code_select(scs),
		.i_reference_clock_in_rate_select(rate), .i_input_clock_select(cksel),
		.i_speed_range_select(spd), .i_parity_check(pc), .i_char(ch),
		.o_out(out), .o_sync_busy(busy), .o_driver_enable(drv),
		.o_chan_power(pwr), .o_bist_active(bist),
		.o_clock_multiplier(mult), .o_config_invalid(inval));
	qtx_rx_model i_qtx_rx_model (.i_clk(clk), .i_out(out[0]),
		.o_period(rx_period), .o_done(rx_done));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk

	// one edge samples what was driven, then look at the settled result
	task settle;
		@(posedge clk);
		@(negedge clk);
	endtask : settle

	task wrap_up;
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1; ole = 1'b1; stle = 1'b0; scs = 1'b0; rate = 1'b0;
		pc = 1'b1; bus = 8'hff; cksel = QTX_CK_REF; spd = QTX_SPD_MID;
		for (int c = 0; c < 4; c++)
			ch[c] = {8'h00, QTX_CTL_DATA, 1'b1};
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk("drv_rst", 32'h00, drv);
		chk("pwr_rst", 32'h0, pwr);
		chk("bist_rst", 32'h0, bist);
		chk("busy_rst", 32'h0, busy);
		chk("kind_rst", QTX_OUT_OFF, out[0].kind);
		chk("mult_rst", QTX_MUL_FULL, mult);
		@(posedge clk) rst <= 1'b0;
		settle;
		chk("drv_strap", 32'hff, drv);
		// drivers just came up from all off: let them settle first
		repeat (QTX_SETTLE_CYC) @(posedge clk);
		@(posedge clk) bus <= 8'h1c;
		settle;
		chk("drv_pass", 32'h1c, drv);
		chk("pwr_pair", 32'h6, pwr);
		@(posedge clk) begin
			ole <= 1'b0;
			bus <= 8'hff;
		end
		settle;
		chk("drv_hold", 32'h1c, drv);
		chk("kind_off", QTX_OUT_OFF, out[0].kind);
		@(posedge clk) ole <= 1'b1;
		@(posedge clk) ole <= 1'b0;
		settle;
		chk("drv_load", 32'hff, drv);
		// data, fill and special characters, select input toggled
		for (int k = 0; k < 3; k++) begin
			@(posedge clk) begin
				ch[1] <= {8'h3c + 8'(k), 2'(k), 1'b1};
				scs <= ~scs;
			end
			settle;
			chk("kind_ctl", 32'(k), out[1].kind);
			if (k != 1)
				chk("data_ctl", 32'h3c + k, out[1].data[7:0]);
		end
		// word sync: inputs changed mid-sequence must be ignored
		@(posedge clk) ch[2] <= {8'h55, QTX_CTL_SYNC, 1'b1};
		@(posedge clk) ch[2] <= {8'h55, QTX_CTL_SPEC, 1'b1};
		for (int k = 1; k <= 16; k++) begin
			@(negedge clk);
			chk("sync_kind", QTX_OUT_SYNC, out[2].kind);
			chk("sync_inv", 32'(k == 2 || k == 3), out[2].invert_disp);
			chk("sync_busy", 32'h1, busy[2]);
		end
		@(negedge clk);
		chk("sync_end", QTX_OUT_SPEC, out[2].kind);
		chk("sync_idle", 32'h0, busy[2]);
		// sync request with bad parity must not start
		@(posedge clk) ch[3] <= {8'h00, QTX_CTL_SYNC, 1'b0};
		settle;
		chk("par_busy", 32'h0, busy[3]);
		chk("par_kind", QTX_OUT_FILL, out[3].kind);
		@(posedge clk) pc <= 1'b0;
		settle;
		chk("nopar_busy", 32'h1, busy[3]);
		@(posedge clk) begin
			pc <= 1'b1;
			ch[3] <= {8'h00, QTX_CTL_DATA, 1'b1};
		end
		@(posedge clk) begin
			rate <= 1'b1;
			cksel <= QTX_CK_CHAN;
		end
		settle;
		chk("mult_half", QTX_MUL_HALF, mult);
		chk("inval", 32'h1, inval);
		@(posedge clk) begin
			cksel <= QTX_CK_REF;
			spd <= QTX_SPD_LOW;
		end
		settle;
		chk("inval_spd", 32'h1, inval);
		@(posedge clk) spd <= QTX_SPD_MID;
		settle;
		chk("inval_ok", 32'h0, inval);
		@(posedge clk) rate <= 1'b0;
		settle;
		chk("inval_off", 32'h0, inval);
		chk("mult_full", QTX_MUL_FULL, mult);
		// self test: even bits do nothing, odd bit low enables lane A
		@(posedge clk) begin
			stle <= 1'b1;
			bus <= 8'haa;
		end
		settle;
		chk("bist_even", 32'h0, bist);
		@(posedge clk) bus <= 8'hfd;
		@(posedge clk) ch[0] <= {8'h99, QTX_CTL_SYNC, 1'b1};
		@(negedge clk);
		chk("bist_on", 32'h1, bist);
		@(posedge clk) begin
			stle <= 1'b0;
			bus <= 8'h57;
		end
		settle;
		chk("bist_hold", 32'h1, bist);
		chk("bist_kind", QTX_OUT_BIST, out[0].kind);
		chk("bist_busy", 32'h0, busy[0]);
		for (int n = 0; n < 1100 && rx_done !== 1'b1; n++)
			@(negedge clk);
		if (rx_done !== 1'b1) begin
			n_errors++;
			$display("BAD bist_done exp 1 got %b", rx_done);
		end else begin
			chk("bist_period", 32'h0000_01ff, rx_period);
		end
		wrap_up;
	end
endmodule : testbench
